// ### lds_asserts.sv
// checker on the ports of the serial dimmer block
module lds_asserts (
  // clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_pin,
  // ports
  input wire logic host_serial_clock,
  input wire logic frame_active,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic [lds_pkg::DIM_W-1:0] photo_sensor_input,
  input wire lds_pkg::lds_mon_t monitor_sigs,
  input wire logic [lds_pkg::DIM_W-1:0] dim_level,
  input wire logic monitor_out_pin,
  input wire lds_pkg::lds_regs_t regs
);
  import lds_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || reset_pin);
  sequence idle_s; !frame_active [*8]; endsequence
  sequence calm_s;
    ($stable(regs) && $stable(monitor_sigs)
      && $stable(photo_sensor_input)) [*4];
  endsequence
  reset_val_a: assert property (
    $fell(rst) |-> regs == {DIM_RESET, TSEL_RESET, SETUP_RESET}
      && dim_level == DIM_RESET) else $error("reset");
  pin_reset_a: assert property (disable iff (rst)
    $rose(reset_pin) |-> ##[1:5] regs == {DIM_RESET, TSEL_RESET,
      SETUP_RESET}) else $error("pin reset");
  reg_dim_a: assert property (
    calm_s ##0 regs.setup[SETUP_REGDIM_BIT] |-> dim_level == regs.dim)
    else $error("reg dim");
  photo_dim_a: assert property (
    calm_s ##0 !regs.setup[SETUP_REGDIM_BIT]
      |-> dim_level == photo_sensor_input) else $error("photo dim");
  monitor_sel_a: assert property (
    calm_s |-> monitor_out_pin == (regs.setup[SETUP_GROUP_BIT] ?
      monitor_sigs.group2[regs.tsel] : monitor_sigs.group1[regs.tsel]))
    else $error("monitor");
  read_edge_a: assert property (
    serial_data_line_oe && $changed(serial_data_line_out)
      |-> host_serial_clock) else $error("read edge");
  oe_idle_a: assert property (
    idle_s |-> !serial_data_line_oe) else $error("idle drive");
  idle_hold_a: assert property (
    idle_s |-> $stable(regs)) else $error("idle write");
endmodule
bind lds_serial_regs lds_asserts u_chk (.*);

// ### lds_host_model.sv
// host model driving the serial link of the dimmer block
module lds_host_model (
  // link
  output logic host_serial_clock,
  output logic frame_active,
  output logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hv = 1'b0;
  logic [23:0] word;
  event got;
  initial {host_serial_clock, frame_active} = 2'h0;
  // the block wins the wire while enabled; released host bits toggle
  assign serial_data_line_in = serial_data_line_oe === 1'b1 ?
    serial_data_line_out : hv;
  task automatic frame(logic [2:0] a, logic rd, logic [15:0] w, int nw);
    logic [20:0] s;
    s = {~hv, a, rd, w};
    // start off the block's clock edge so no link edge races it
    #1 frame_active = 1'b1;
    for (int i = 0; i < (rd ? 29 : 5 + nw); i++) begin
      hv = (rd && i > 4) ? ~hv : s[20-i];
      #62.5 host_serial_clock = 1'b1;
      #62.5 host_serial_clock = 1'b0;
      if (rd && i > 4) word = {word[22:0], serial_data_line_in};
    end
    #200 frame_active = 1'b0;
    if (rd) ->got;
    #300;
  endtask
endmodule

// ### lds_pkg.sv
// package: constants and types of the serial dimmer control block
package lds_pkg;
  // frame layout, host to device, msb first after one discarded bit
  localparam int ADDR_W = 3;
  localparam int DIM_W = 8;
  localparam int TSEL_W = 4;
  localparam int SETUP_W = 4;
  localparam int WR_BITS = ADDR_W + DIM_W + TSEL_W + SETUP_W;
  localparam int RD_BITS = 24;
  localparam int CNT_W = 6;
  // setup field positions
  localparam int SETUP_REGDIM_BIT = 1;
  localparam int SETUP_GROUP_BIT = 3;
  // reset values
  localparam logic [DIM_W-1:0] DIM_RESET = 8'hFF;
  localparam logic [TSEL_W-1:0] TSEL_RESET = 4'h0;
  localparam logic [SETUP_W-1:0] SETUP_RESET = 4'h0;
  localparam logic CHIP_SEL_BIT2 = 1'b0;
  // sensor byte layout: 6-bit result in bits 7..2
  localparam int SENSE_W = 6;
  localparam int SENSE_LSB = 2;
  // direction bit after the address: 1 reads
  localparam logic DIR_READ = 1'b1;

  typedef struct packed {
    logic [DIM_W-1:0] dim;
    logic [TSEL_W-1:0] tsel;
    logic [SETUP_W-1:0] setup;
  } lds_regs_t;

  typedef struct packed {
    logic [15:0] group1;
    logic [15:0] group2;
  } lds_mon_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ = 2'b11
  } lds_state_t;
endpackage

// ### lds_serial_regs.sv
// module: serial register interface of the led dimmer
// Behaviour
// (R1) chip address from two straps, bit2 zero
// (R2) act only on matching frame address
// (R3) dim FFh brightest, 01h deepest dimming
// (R4) register dimming needs setup bit 1 set
// (R5) setup bit1 zero selects photo sensor
// (R6) setup bit 3 picks monitor group
// (R7) test select picks monitor signal
// (R8) sample on clock edges, drop first bit
// (R9) read data changes on rising clock edge
// (R10) read returns dim, temperature, ambient bytes
// (R11) host writes address, dim, test, setup
// (R12) temperature result in bits 7 to 2
// (R13) ambient result in bits 7 to 2
// (R14) reset pin clears interface and registers
module lds_serial_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // reset pin from outside
  input wire logic reset_pin,
  // address straps
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  // serial link
  input wire logic host_serial_clock,
  input wire logic serial_data_line_in,
  input wire logic frame_active,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  // analog side values
  input wire logic [lds_pkg::SENSE_W-1:0] temp_result,
  input wire logic [lds_pkg::SENSE_W-1:0] ambient_result,
  input wire logic [lds_pkg::DIM_W-1:0] photo_sensor_input,
  input wire lds_pkg::lds_mon_t monitor_sigs,
  // outputs
  output logic [lds_pkg::DIM_W-1:0] dim_level,
  output logic reg_dim_active,
  output logic monitor_out_pin,
  output lds_pkg::lds_regs_t regs
);
  import lds_pkg::*;

  logic [4:0] s1_q, s2_q;
  logic sck_prev_q, sck_prev_d;
  logic sck, din, fr, rpin, sda0, sda1;
  logic [1:0] strap_q, strap_d;
  lds_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [WR_BITS-1:0] sh_q, sh_d;
  logic [RD_BITS-1:0] rd_q, rd_d;
  logic out_q, out_d, oe_q, oe_d;
  lds_regs_t regs_q, regs_d;
  logic [DIM_W-1:0] dim_q, dim_d;
  logic mon_q, mon_d;
  // set once a frame is refused or complete; cleared when the frame ends
  logic lock_q, lock_d;
  logic rise, fall, clr;
  logic [ADDR_W-1:0] my_addr, rx_addr;
  logic [DIM_W-1:0] temp_byte, ambient_byte;

  // two-stage synchronisers for the link, reset pin and bit1 strap inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      s1_q <= {reset_pin, frame_active, serial_data_line_in,
               chip_sel_bit1, host_serial_clock};
      s2_q <= s1_q;
    end
  end
  assign sck = s2_q[0];
  assign sda1 = s2_q[1];
  assign din = s2_q[2];
  assign fr = s2_q[3];
  assign rpin = s2_q[4];

  // bit0 strap shares no slot above; synchronise separately
  logic b0_1_q, b0_2_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      b0_1_q <= 1'b0;
      b0_2_q <= 1'b0;
    end else begin
      b0_1_q <= chip_sel_bit0;
      b0_2_q <= b0_1_q;
    end
  end
  assign sda0 = b0_2_q;

  assign rise = sck & ~sck_prev_q; // (R8)
  assign fall = ~sck & sck_prev_q; // (R8)
  assign clr = rpin; // (R14)
  assign my_addr = {CHIP_SEL_BIT2, strap_q}; // (R1)
  assign rx_addr = sh_q[ADDR_W-1:0];
  assign temp_byte = {temp_result, {SENSE_LSB{1'b0}}}; // (R12)
  assign ambient_byte = {ambient_result, {SENSE_LSB{1'b0}}}; // (R13)

  always_comb begin
    sck_prev_d = sck;
    strap_d = {sda1, sda0}; // (R1)
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    out_d = out_q;
    oe_d = oe_q;
    regs_d = regs_q;
    lock_d = lock_q;
    if (clr || !fr) begin
      st_d = ST_IDLE;
      cnt_d = '0;
      oe_d = 1'b0;
      out_d = 1'b0;
      lock_d = 1'b0;
      if (clr) begin
        regs_d = '{dim: DIM_RESET, tsel: TSEL_RESET, setup: SETUP_RESET};
      end
    end else if (!lock_q) begin
      // without the lock, trailing bits would be parsed as a new header
      case (st_q)
        ST_IDLE: begin
          // first sampled bit of a frame is dropped
          if (rise) begin
            st_d = ST_HEAD; // (R8)
            cnt_d = '0;
          end
        end
        ST_HEAD: begin
          if (rise) begin
            sh_d = {sh_q[WR_BITS-2:0], din};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(ADDR_W)) begin
              // address done, this bit is direction
              if (rx_addr != my_addr) begin
                st_d = ST_IDLE; // (R2)
                cnt_d = '0;
                lock_d = 1'b1; // (R2)
              end else if (din == DIR_READ) begin
                st_d = ST_READ;
                cnt_d = '0;
                rd_d = {dim_q, temp_byte, ambient_byte}; // (R10)
              end else begin
                st_d = ST_WRITE;
                cnt_d = '0;
              end
            end
          end
        end
        ST_WRITE: begin
          if (rise) begin
            sh_d = {sh_q[WR_BITS-2:0], din};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(DIM_W + TSEL_W + SETUP_W - 1)) begin
              // dim, test select, setup order from host
              regs_d = lds_regs_t'({sh_q[DIM_W+TSEL_W+SETUP_W-2:0],
                                    din}); // (R11)
              st_d = ST_IDLE;
              lock_d = 1'b1;
            end
          end
        end
        ST_READ: begin
          if (rise) begin
            oe_d = 1'b1;
            out_d = rd_q[RD_BITS-1]; // (R9)
            rd_d = {rd_q[RD_BITS-2:0], 1'b0};
            cnt_d = cnt_q + 1'b1;
          end else if (fall && cnt_q == CNT_W'(RD_BITS)) begin
            oe_d = 1'b0;
            st_d = ST_IDLE;
            lock_d = 1'b1;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // dimming path and monitor selection
  always_comb begin
    if (regs_q.setup[SETUP_REGDIM_BIT]) begin
      dim_d = regs_q.dim; // (R4) (R3)
    end else begin
      dim_d = photo_sensor_input; // (R5)
    end
    if (regs_q.setup[SETUP_GROUP_BIT]) begin
      mon_d = monitor_sigs.group2[regs_q.tsel]; // (R6) (R7)
    end else begin
      mon_d = monitor_sigs.group1[regs_q.tsel]; // (R6) (R7)
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      strap_q <= 2'b00;
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      rd_q <= '0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      regs_q <= '{dim: DIM_RESET, tsel: TSEL_RESET, setup: SETUP_RESET};
      dim_q <= DIM_RESET;
      mon_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_prev_d;
      strap_q <= strap_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      out_q <= out_d;
      oe_q <= oe_d;
      regs_q <= regs_d;
      dim_q <= dim_d;
      mon_q <= mon_d;
      lock_q <= lock_d;
    end
  end

  assign serial_data_line_out = out_q;
  assign serial_data_line_oe = oe_q;
  assign dim_level = dim_q;
  assign reg_dim_active = regs_q.setup[SETUP_REGDIM_BIT];
  assign monitor_out_pin = mon_q;
  assign regs = regs_q;
endmodule

// ### lds_serial_regs_tb_top.sv
// bench for the serial dimmer block
module lds_serial_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lds_pkg::*;
  logic clock = 1'b0, rst = 1'b1, reset_pin = 1'b0;
  logic chip_sel_bit0 = 1'b0, chip_sel_bit1 = 1'b0;
  logic host_serial_clock, serial_data_line_in, frame_active;
  logic serial_data_line_out, serial_data_line_oe;
  logic reg_dim_active, monitor_out_pin;
  logic [SENSE_W-1:0] temp_result = '0, ambient_result = '0;
  logic [DIM_W-1:0] photo_sensor_input = '0, dim_level;
  lds_mon_t monitor_sigs = '0;
  lds_regs_t regs;
  logic [31:0] seed = 32'h1F, r;
  logic [15:0] w;
  logic [2:0] a;
  logic [7:0] ed;
  logic em;
  int error_cnt = 0, comparisons = 0;
  logic [23:0] expq[$];
  lds_serial_regs dut (.*);
  lds_host_model host (.*);
  initial forever #5 clock = ~clock;
  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [23:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(host.got) chk("rd", expq.pop_front(), host.word);
  initial begin
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      #1 r = rnd();
      // dim kept odd, setup bit 1 alternates
      w = {r[15:9], 1'b1, r[23:18], k[0], r[16]};
      {chip_sel_bit1, chip_sel_bit0} = r[25:24];
      a = {1'b0, r[25:24]};
      {temp_result, ambient_result, photo_sensor_input} = r[31:12];
      monitor_sigs = rnd();
      repeat (5) @(posedge clock);
      host.frame(a ^ 3'h3, 1'b0, ~w, 16);
      host.frame(a, 1'b0, w, 16);
      host.frame(a, 1'b0, ~w, 10);
      chk("regs", 24'(w), 24'(regs));
      ed = k[0] ? w[15:8] : photo_sensor_input;
      em = w[3] ? monitor_sigs.group2[w[7:4]] : monitor_sigs.group1[w[7:4]];
      chk("dim", 24'(ed), 24'(dim_level));
      chk("regdim", 24'(k[0]), 24'(reg_dim_active));
      chk("mon", 24'(em), 24'(monitor_out_pin));
      expq.push_back({k[0] ? w[15:8] : photo_sensor_input,
        temp_result, 2'h0, ambient_result, 2'h0});
      host.frame(a, 1'b1, 16'h0000, 0);
    end
    @(posedge clock);
    #1 reset_pin = 1'b1;
    repeat (8) @(posedge clock);
    chk("rst", 24'({DIM_RESET, TSEL_RESET, SETUP_RESET}), 24'(regs));
    print_verdict();
  end
endmodule
